// [include/tape_timing_pkg.sv]
`default_nettype none
package tape_timing_pkg;
    // Clock and tick timing
    localparam int CLOCK_HZ = 20000000;
    localparam int MASTER_HZ = 4000000;
    localparam int MASTER_DIV = CLOCK_HZ / MASTER_HZ;
    localparam logic [3:0] DIV_PRESET = 4'h6;
    localparam logic [3:0] DIV_FULL = 4'hf;
    localparam int WSTROBE_DIV = 4;
    // Instruction field positions
    localparam int UNIT_LO_BIT = 9;
    localparam int UNIT_HI_BIT = 10;
    localparam int DD_LO_BIT = 1;
    localparam int DD_HI_BIT = 8;
    localparam int LONG_LO_BIT = 2;
    // Command register bit positions
    localparam int CMD_FORWARD = 0;
    localparam int CMD_REVERSE = 1;
    localparam int CMD_REWIND = 2;
    localparam int CMD_OFFLINE = 3;
    localparam int CMD_RECOVERY = 4;
    localparam int CMD_WRESET = 5;
    localparam int CMD_WSTROBE = 6;
    localparam int CMD_WCURRENT = 7;
    // Reset values
    localparam logic [1:0] UNIT_RESET = 2'h0;
    localparam logic [7:0] CMD_RESET = 8'h00;
    localparam logic [7:0] WCLK_RESET = 8'h00;

    typedef struct packed {
        logic unit_select_load_subfunc;
        logic unit_select_clear_subfunc;
        logic command_reg_clear_subfunc;
        logic write_clock_load_code;
        logic command_reg_load_code;
        logic long_timer_load_code;
        logic short_timer_load_code;
    } micro_strobes_t;

    typedef struct packed {
        logic tick_2u5;
        logic tick_25u;
        logic tick_250u;
    } ticks_t;
endpackage
`default_nettype wire

// [hw/decade_divider.sv]
`timescale 1ns/10ps
`default_nettype none
module decade_divider
    import tape_timing_pkg::*;
(
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rst,
    // Count enable
    input wire logic i_enable,
    // Carry pulse
    output logic o_carry
);
    logic [3:0] count_q;

    // Preset to 6, carry on tenth increment
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            count_q <= DIV_PRESET;
            o_carry <= 1'b0;
        end else begin
            o_carry <= 1'b0;
            if (i_enable) begin
                if (count_q == DIV_FULL) begin
                    count_q <= DIV_PRESET;
                    o_carry <= 1'b1;
                end else begin
                    count_q <= count_q + 4'h1;
                end
            end
        end
    end
endmodule
`default_nettype wire

// [hw/tape_drive_timing_and_command.sv]
// Contract
// (RULE1) Unit number comes from command bits 9 and 10.
// (RULE2) Unit select load asserts exactly one of four select lines.
// (RULE3) Unit select clear drops all select lines.
// (RULE4) Command load with bits 1-4 equal 8 sets the forward latch; the code ORs instruction bit 1 alone into it.
// (RULE5) A second command load sets write current and write strobe latches.
// (RULE6) Command register drives eight drive control outputs.
// (RULE7) Command register clear resets all eight bits.
// (RULE8) Write clock rate is programmable for all densities.
// (RULE9) Master clock phases are 4 MHz, complementary.
// (RULE10) Active-high phase steps the microprogram address counter each 250 ns.
// (RULE11) Active-low phase shifts the data registers enabled before.
// (RULE12) Write clock control loads from direct data bits 1-8.
// (RULE13) Control register holds complement, always feeding the counter.
// (RULE14) Counter increments at master rate; every fourth overflow is a strobe.
// (RULE15) Each strobe sets the strobe-seen flag.
// (RULE16) Three decade dividers give 2.5, 25 and 250 us ticks.
// (RULE17) Timers load the complement and count up to overflow.
// (RULE18) Short timer counts at 2.5 us, halves chained, stops on done.
// (RULE19) Long timer counts at 250 us tick.
// (RULE20) Long timer loads from bits 2-8, done flag on its output.
// (RULE21) Short timer loads from bits 1-8.
// (RULE22) Overflow gives a one-cycle low pulse and reload.
// (RULE23) Reset clears unit select, command register and strobe-seen flag.
`timescale 1ns/10ps
`default_nettype none
module tape_drive_timing_and_command
    import tape_timing_pkg::*;
(
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rst,
    // Microcode strobes and instruction bits, bit 0 unused
    input wire micro_strobes_t i_strobes,
    input wire logic [16:0] i_instruction_bits,
    input wire logic [16:0] i_io_command,
    // Strobe-seen flag acknowledge
    input wire logic i_write_strobe_seen_clear,
    // Master clock phases and steps
    output logic o_master_clock_phase,
    output logic o_master_clock_phase_n,
    output logic o_address_step,
    output logic o_shift_step,
    // Drive outputs
    output logic [3:0] o_drive_select,
    output logic [7:0] o_drive_command,
    output logic o_forward_motion_line,
    output logic o_write_strobe,
    output logic o_write_counter_overflow_pulse_n,
    // Feedback flags
    output logic o_short_timer_done_flag,
    output logic o_long_timer_done_flag,
    output logic o_write_strobe_seen_flag,
    output var ticks_t o_ticks
);
    logic [2:0] phase_cnt_q;
    logic master_tick;
    logic [7:0] wclk_ctrl_q;
    logic [7:0] wclk_cnt_q;
    logic [1:0] wdiv_q;
    logic [7:0] short_q;
    logic short_lo_carry_q;
    logic [7:0] long_q;
    logic c1;
    logic c2;
    logic c3;

    function automatic logic [7:0] inv_bits(input logic [16:0] b, input int lo);
        logic [7:0] r;
        r = 8'hff;
        for (int i = 0; i < 8; i++) begin
            if (lo + i <= DD_HI_BIT) begin
                r[i] = ~b[lo + i];
            end
        end
        return r;
    endfunction

    // Master clock: divide to 4 MHz with two phases
    assign master_tick = (phase_cnt_q == 3'(MASTER_DIV - 1));
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            phase_cnt_q <= 3'h0;
            o_master_clock_phase <= 1'b0;
            o_master_clock_phase_n <= 1'b1;
            o_address_step <= 1'b0;
            o_shift_step <= 1'b0;
        end else begin
            phase_cnt_q <= master_tick ? 3'h0 : phase_cnt_q + 3'h1;
            o_master_clock_phase <= (phase_cnt_q < 3'(MASTER_DIV / 2)); // [RULE9]
            o_master_clock_phase_n <= ~(phase_cnt_q < 3'(MASTER_DIV / 2)); // [RULE9]
            o_address_step <= master_tick; // [RULE10]
            o_shift_step <= (phase_cnt_q == 3'(MASTER_DIV / 2)); // [RULE11]
        end
    end

    // Decade divider chain
    decade_divider u_div0 (.i_clock(i_clock), .i_rst(i_rst), .i_enable(master_tick),
        .o_carry(c1)); // [RULE16]
    decade_divider u_div1 (.i_clock(i_clock), .i_rst(i_rst), .i_enable(c1),
        .o_carry(c2)); // [RULE16]
    decade_divider u_div2 (.i_clock(i_clock), .i_rst(i_rst), .i_enable(c2),
        .o_carry(c3)); // [RULE16]
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            o_ticks <= '0;
        end else begin
            o_ticks <= '{tick_2u5: c1, tick_25u: c2, tick_250u: c3};
        end
    end

    // Unit select register
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            o_drive_select <= 4'h0; // [RULE23]
        end else if (i_strobes.unit_select_clear_subfunc) begin
            o_drive_select <= 4'h0; // [RULE3]
        end else if (i_strobes.unit_select_load_subfunc) begin
            o_drive_select <= 4'h1 << i_io_command[UNIT_HI_BIT:UNIT_LO_BIT]; // [RULE1] [RULE2]
        end
    end

    // Drive command register, load ORs the data bits into the latches
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            o_drive_command <= CMD_RESET; // [RULE23]
            o_forward_motion_line <= 1'b0;
        end else if (i_strobes.command_reg_clear_subfunc) begin
            o_drive_command <= CMD_RESET; // [RULE7]
            o_forward_motion_line <= 1'b0;
        end else if (i_strobes.command_reg_load_code) begin
            o_drive_command <= o_drive_command
                | i_instruction_bits[DD_HI_BIT:DD_LO_BIT]; // [RULE4] [RULE5] [RULE6]
            o_forward_motion_line <= o_drive_command[CMD_FORWARD]
                | i_instruction_bits[DD_LO_BIT + CMD_FORWARD]; // [RULE4]
        end
    end

    // Write clock control and counter
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            wclk_ctrl_q <= WCLK_RESET;
        end else if (i_strobes.write_clock_load_code) begin
            wclk_ctrl_q <= inv_bits(i_instruction_bits, DD_LO_BIT); // [RULE12] [RULE13] [RULE8]
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            wclk_cnt_q <= WCLK_RESET;
            wdiv_q <= 2'h0;
            o_write_counter_overflow_pulse_n <= 1'b1;
            o_write_strobe <= 1'b0;
        end else begin
            o_write_counter_overflow_pulse_n <= 1'b1;
            o_write_strobe <= 1'b0;
            if (master_tick) begin
                if (wclk_cnt_q == 8'hff) begin
                    wclk_cnt_q <= wclk_ctrl_q; // [RULE22]
                    o_write_counter_overflow_pulse_n <= 1'b0; // [RULE22]
                    wdiv_q <= wdiv_q + 2'h1; // [RULE14]
                    o_write_strobe <= (wdiv_q == 2'(WSTROBE_DIV - 1)); // [RULE14]
                end else begin
                    wclk_cnt_q <= wclk_cnt_q + 8'h01; // [RULE14]
                end
            end
        end
    end

    // Strobe-seen flag, set wins over clear
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            o_write_strobe_seen_flag <= 1'b0; // [RULE23]
        end else if (o_write_strobe) begin
            o_write_strobe_seen_flag <= 1'b1; // [RULE15]
        end else if (i_write_strobe_seen_clear) begin
            o_write_strobe_seen_flag <= 1'b0;
        end
    end

    // Short timer: two chained nibbles
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            short_q <= 8'h00;
            short_lo_carry_q <= 1'b0;
            o_short_timer_done_flag <= 1'b0;
        end else if (i_strobes.short_timer_load_code) begin
            short_q <= inv_bits(i_instruction_bits, DD_LO_BIT); // [RULE17] [RULE21]
            short_lo_carry_q <= 1'b0;
            o_short_timer_done_flag <= 1'b0;
        end else if (c1 && !o_short_timer_done_flag) begin
            short_q[3:0] <= short_q[3:0] + 4'h1; // [RULE18]
            if (short_q[3:0] == 4'hf) begin
                short_q[7:4] <= short_q[7:4] + 4'h1; // [RULE18]
                if (short_q[7:4] == 4'hf) begin
                    o_short_timer_done_flag <= 1'b1; // [RULE18]
                end
            end
        end
    end

    // Long timer: data in bits 7..1, bit 0 low, two ticks a step
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            long_q <= 8'h00;
            o_long_timer_done_flag <= 1'b0;
        end else if (i_strobes.long_timer_load_code) begin
            long_q <= inv_bits(i_instruction_bits, LONG_LO_BIT - 1) & 8'hfe; // [RULE17] [RULE20]
            o_long_timer_done_flag <= 1'b0;
        end else if (c3 && !o_long_timer_done_flag) begin
            long_q <= long_q + 8'h01; // [RULE19]
            if (long_q == 8'hff) begin
                o_long_timer_done_flag <= 1'b1; // [RULE20]
            end
        end
    end
endmodule
`default_nettype wire

// [sim/tape_drive_model.sv]
`timescale 1ns/10ps
`default_nettype none
module tape_drive_model
    import tape_timing_pkg::*;
(
    // Clock
    input wire logic i_clock,
    // Drive lines
    input wire logic [3:0] i_drive_select,
    input wire logic [7:0] i_drive_command,
    input wire logic i_write_strobe,
    // Measured strobe spacing
    output logic [15:0] o_strobe_gap
);
    logic [15:0] since_q = 16'h0;
    // Spacing of data clocks on a selected, writing drive
    always_ff @(posedge i_clock) begin
        if (i_write_strobe && |i_drive_select && i_drive_command[CMD_WCURRENT]) begin
            o_strobe_gap <= since_q + 16'h1;
            since_q <= 16'h0;
        end else begin
            since_q <= since_q + 16'h1;
        end
    end
endmodule
`default_nettype wire

// [sim/tape_timing_asserts.sv]
`timescale 1ns/10ps
`default_nettype none
module tape_timing_asserts
    import tape_timing_pkg::*;
(
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rst,
    // Watched ports
    input wire micro_strobes_t i_strobes,
    input wire logic [16:0] i_io_command,
    input wire logic o_master_clock_phase,
    input wire logic o_master_clock_phase_n,
    input wire logic o_address_step,
    input wire logic o_shift_step,
    input wire logic [3:0] o_drive_select,
    input wire logic [7:0] o_drive_command,
    input wire logic o_forward_motion_line,
    input wire logic o_write_strobe,
    input wire logic o_write_counter_overflow_pulse_n,
    input wire logic o_write_strobe_seen_flag,
    input wire ticks_t o_ticks
);
    logic [3:0] sel_exp_q;
    always_ff @(posedge i_clock) begin
        sel_exp_q <= 4'h1 << i_io_command[10:9];
    end
    default clocking @(posedge i_clock); endclocking
    default disable iff (i_rst);
    phase_split_a: assert property (o_master_clock_phase != o_master_clock_phase_n)
        else $error("phases not complementary");
    step_period_a: assert property (o_address_step |=> !o_address_step [*4] ##1 o_address_step)
        else $error("address step period wrong");
    shift_mid_a: assert property (o_address_step |-> ##[1:4] o_shift_step)
        else $error("shift step missing");
    unit_load_a: assert property (i_strobes.unit_select_load_subfunc && !i_strobes.unit_select_clear_subfunc |=> o_drive_select == sel_exp_q)
        else $error("unit select wrong");
    unit_clear_a: assert property (i_strobes.unit_select_clear_subfunc |=> o_drive_select == 4'h0)
        else $error("unit select not cleared");
    cmd_clear_a: assert property (i_strobes.command_reg_clear_subfunc |=> o_drive_command == 8'h00)
        else $error("command not cleared");
    fwd_line_a: assert property (o_forward_motion_line == o_drive_command[CMD_FORWARD])
        else $error("forward line mismatch");
    seen_set_a: assert property (o_write_strobe |=> o_write_strobe_seen_flag)
        else $error("strobe seen flag not set");
    ovf_pulse_a: assert property ($fell(o_write_counter_overflow_pulse_n) |=> o_write_counter_overflow_pulse_n)
        else $error("overflow pulse too long");
    tick_period_a: assert property (o_ticks.tick_2u5 |-> ##50 o_ticks.tick_2u5)
        else $error("short tick period wrong");
    reset_clear_a: assert property ($fell(i_rst) |-> o_drive_select == 4'h0 && o_drive_command == 8'h00 && !o_write_strobe_seen_flag)
        else $error("reset values wrong");
endmodule
`default_nettype wire

// [sim/tape_drive_timing_and_command_tb.sv]
`timescale 1ns/10ps
`default_nettype none
module tape_drive_timing_and_command_tb;
    import tape_timing_pkg::*;
    logic i_clock = 1'b0;
    logic i_rst = 1'b1;
    micro_strobes_t strb = '0;
    logic [16:0] ibits = 17'h0;
    logic seen_clr = 1'b0;
    logic ph, ph_n, astep, sstep, forward_motion_line, wstb, ovf_n, sdone, ldone, seen;
    logic [3:0] dsel;
    logic [7:0] dcmd;
    ticks_t ticks;
    logic [15:0] gap;
    logic [4:0] watch;
    int fails = 0;
    int num_checks = 0;
    int c;
    int dv[3] = '{0, 3, 9};
    assign watch = {ticks, sdone, wstb};
    tape_drive_timing_and_command DUT (.i_clock(i_clock), .i_rst(i_rst), .i_strobes(strb),
        .i_instruction_bits(ibits), .i_io_command(ibits), .i_write_strobe_seen_clear(seen_clr),
        .o_master_clock_phase(ph), .o_master_clock_phase_n(ph_n), .o_address_step(astep),
        .o_shift_step(sstep), .o_drive_select(dsel), .o_drive_command(dcmd),
        .o_forward_motion_line(forward_motion_line), .o_write_strobe(wstb),
        .o_write_counter_overflow_pulse_n(ovf_n), .o_short_timer_done_flag(sdone),
        .o_long_timer_done_flag(ldone), .o_write_strobe_seen_flag(seen), .o_ticks(ticks));
    tape_drive_model drive (.i_clock(i_clock), .i_drive_select(dsel), .i_drive_command(dcmd),
        .i_write_strobe(wstb), .o_strobe_gap(gap));
    initial begin
        forever #25 i_clock = ~i_clock;
    end
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic issue(input micro_strobes_t s, input logic [16:0] b);
        @(posedge i_clock);
        #2;
        strb = s;
        ibits = b;
        @(posedge i_clock);
        #2;
        strb = '0;
    endtask
    task automatic wait_on(input int w);
        c = 0;
        do begin
            @(posedge i_clock);
            #2;
            c++;
        end while (!watch[w] && c < 20000);
    endtask
    task automatic print_verdict();
        $display("checks %0d fails %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        #3000000;
        fails++;
        print_verdict();
    end
    initial begin
        repeat (6) @(posedge i_clock);
        #2;
        i_rst = 1'b0;
        check("select", 4'h0, dsel);
        check("command", 8'h00, dcmd);
        check("phase_n", 1'b1, ph_n);
        for (int u = 0; u < 4; u++) begin
            issue(7'h40, 17'(u) << 9);
            check("select", 4'h1 << u, dsel);
        end
        issue(7'h60, 17'h00200);
        check("select", 4'h0, dsel);
        issue(7'h04, 17'h00002);
        check("forward", 1'b1, forward_motion_line);
        issue(7'h04, 17'h00180);
        check("command", 8'hc1, dcmd);
        for (int b = 0; b < 8; b++) begin
            issue(7'h10, 17'h0);
            issue(7'h04, 17'h2 << b);
            check("command", 8'h1 << b, dcmd);
        end
        issue(7'h14, 17'h1fe);
        check("command", 8'h00, dcmd);
        issue(7'h44, 17'h00100);
        foreach (dv[i]) begin
            issue(7'h08, 17'(dv[i]) << 1);
            repeat (3) wait_on(0);
            check("strobe_gap", (dv[i] + 1) * 4 * MASTER_DIV, gap);
        end
        @(posedge i_clock);
        #2;
        check("seen", 1'b1, seen);
        seen_clr = 1'b1;
        @(posedge i_clock);
        #2;
        seen_clr = 1'b0;
        check("seen", 1'b0, seen);
        for (int n = 0; n < 3; n += 2) begin
            issue(7'h01, 17'(n) << 1);
            check("short_done", 1'b0, sdone);
            wait_on(1);
            check("short_span", 1'b1, c > n * 50 && c <= (n + 1) * 50 + 3);
            repeat (60) @(posedge i_clock);
            #2;
            check("short_done", 1'b1, sdone);
        end
        issue(7'h02, 17'h00004);
        for (int i = 2; i < 5; i++) begin
            wait_on(i);
            wait_on(i);
            check("tick_gap", 50 * 10 ** (4 - i), c);
        end
        check("long_done", 1'b0, ldone);
        wait_on(2);
        wait_on(2);
        check("long_done", 1'b1, ldone);
        print_verdict();
    end
endmodule
bind tape_drive_timing_and_command tape_timing_asserts chk (.i_clock(i_clock), .i_rst(i_rst),
    .i_strobes(i_strobes), .i_io_command(i_io_command),
    .o_master_clock_phase(o_master_clock_phase), .o_master_clock_phase_n(o_master_clock_phase_n),
    .o_address_step(o_address_step), .o_shift_step(o_shift_step),
    .o_drive_select(o_drive_select), .o_drive_command(o_drive_command),
    .o_forward_motion_line(o_forward_motion_line), .o_write_strobe(o_write_strobe),
    .o_write_counter_overflow_pulse_n(o_write_counter_overflow_pulse_n),
    .o_write_strobe_seen_flag(o_write_strobe_seen_flag), .o_ticks(o_ticks));
`default_nettype wire
